// ==== hw/csr_core_regs.v ====
/*
  Core special-function registers: bank pointer, accumulator, program
  counter low byte, table pointers and latch, status flags.
  Assumes one clock, a synchronous active-high reset, and an execution
  unit that presents register accesses and instruction events.
*/
`timescale 1ns/1ps
`include "csr_consts.vh"

module csr_core_regs (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        powerUp,
  input  wire        wdtReset,
  input  wire        idleSleep,
  input  wire        regWrite,
  input  wire        regRead,
  input  wire        indirect,
  input  wire        usePtrB,
  input  wire [7:0]  regAddr,
  input  wire [7:0]  regWdata,
  input  wire        aluValid,
  input  wire        aluArith,
  input  wire        aluSub,
  input  wire        aluUseCarry,
  input  wire [7:0]  aluOpB,
  input  wire [7:0]  logicResult,
  input  wire        tableRead,
  input  wire [15:0] progWord,
  input  wire        wdtTimeout,
  input  wire        wdtClearInstr,
  input  wire        haltInstr,
  output reg  [7:0]  regRdata,
  output reg         memBank,
  output reg  [7:0]  memAddr,
  output reg         memAccess,
  output reg         pcLoad,
  output reg  [7:0]  pcLowByte,
  output reg         dummyCycle,
  output reg  [15:0] tableAddr,
  output reg  [7:0]  accumulator,
  output reg         wdtTimeoutFlag,
  output reg         powerdownFlag
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg        bankSelectBit_r;
  reg [7:0]  memPointerA_r;
  reg [7:0]  memPointerB_r;
  reg [7:0]  tablePtrLow_r;
  reg [7:0]  tablePtrHigh_r;
  reg [7:0]  tableHighLatch_r;
  reg [3:0]  arithFlags_r;
  reg [1:0]  dummyCnt_r;

  wire [7:0] aluSum;
  wire [3:0] aluFlags;
  wire       isSfr;
  wire       wrBank;
  wire       wrFlags;
  reg  [7:0] flagsRead;
  reg  [7:0] rdataNxt;

  // Flag generator on accumulator and second operand
  csr_flag_unit uFlags (
    .opA      (accumulator),
    .opB      (aluOpB),
    .isSub    (aluSub),
    .carryIn  (arithFlags_r[`CSR_FLAG_C]),
    .useCarry (aluUseCarry),
    .sum      (aluSum),
    .flags    (aluFlags)
  );

  // Special registers sit at or below the SFR top in any bank
  assign isSfr   = ~indirect && (regAddr <= `CSR_SFR_TOP);
  assign wrBank  = regWrite && isSfr && (regAddr == `CSR_ADDR_BANK);
  assign wrFlags = regWrite && isSfr && (regAddr == `CSR_ADDR_FLAGS);

  // ----------------------------------------------------------------
  // Data memory bank and address routing
  // ----------------------------------------------------------------
  // Direct goes to bank 0, pointer A to bank 0, pointer B follows bit
  always @(posedge clk) begin
    if (sys_rst) begin
      memBank   <= 1'b0;
      memAddr   <= `CSR_BYTE_RST;
      memAccess <= 1'b0;
    end else begin
      memAccess <= (regWrite || regRead) && !isSfr;
      if (!indirect) begin
        memBank <= 1'b0;
        memAddr <= regAddr;
      end else if (!usePtrB) begin
        memBank <= 1'b0;
        memAddr <= memPointerA_r;
      end else begin
        memBank <= bankSelectBit_r;
        memAddr <= memPointerB_r;
      end
    end
  end

  // Bank select bit; a watchdog reset in idle or sleep keeps it
  always @(posedge clk) begin
    if (sys_rst || powerUp) begin
      bankSelectBit_r <= `CSR_BANK_RST;
    end else if (wdtReset) begin
      if (!idleSleep)
        bankSelectBit_r <= `CSR_BANK_RST;
    end else if (wrBank) begin
      bankSelectBit_r <= regWdata[`CSR_BANK_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Accumulator, pointers and table registers
  // ----------------------------------------------------------------
  // Accumulator gets ALU results; register moves also land here
  always @(posedge clk) begin
    if (sys_rst) begin
      accumulator      <= `CSR_BYTE_RST;
      memPointerA_r    <= `CSR_BYTE_RST;
      memPointerB_r    <= `CSR_BYTE_RST;
      tablePtrLow_r    <= `CSR_BYTE_RST;
      tablePtrHigh_r   <= `CSR_BYTE_RST;
      tableHighLatch_r <= `CSR_BYTE_RST;
    end else begin
      if (aluValid)
        accumulator <= aluArith ? aluSum : logicResult;
      else if (regWrite && isSfr && regAddr == `CSR_ADDR_ACC)
        accumulator <= regWdata;
      if (regWrite && isSfr && regAddr == `CSR_ADDR_PTR_A)
        memPointerA_r <= regWdata;
      if (regWrite && isSfr && regAddr == `CSR_ADDR_PTR_B)
        memPointerB_r <= regWdata;
      if (regWrite && isSfr && regAddr == `CSR_ADDR_TBL_LO)
        tablePtrLow_r <= regWdata;
      if (regWrite && isSfr && regAddr == `CSR_ADDR_TBL_HI_P)
        tablePtrHigh_r <= regWdata;
      if (tableRead)
        tableHighLatch_r <= progWord[15:8];
    end
  end

  // Table address presented to program memory
  always @(posedge clk) begin
    if (sys_rst)
      tableAddr <= 16'h0000;
    else
      tableAddr <= {tablePtrHigh_r, tablePtrLow_r};
  end

  // ----------------------------------------------------------------
  // Program counter low byte and dummy cycle
  // ----------------------------------------------------------------
  // A write loads the low 8 bits and stalls one instruction cycle
  always @(posedge clk) begin
    if (sys_rst) begin
      pcLoad     <= 1'b0;
      pcLowByte  <= `CSR_BYTE_RST;
      dummyCycle <= 1'b0;
      dummyCnt_r <= 2'h0;
    end else begin
      pcLoad <= regWrite && isSfr && regAddr == `CSR_ADDR_PCL;
      if (regWrite && isSfr && regAddr == `CSR_ADDR_PCL) begin
        pcLowByte  <= regWdata;
        dummyCnt_r <= `CSR_PCL_DUMMY_CYC;
        dummyCycle <= 1'b1;
      end else if (dummyCnt_r != 2'h0) begin
        dummyCnt_r <= dummyCnt_r - 2'h1;
        dummyCycle <= (dummyCnt_r > 2'h1);
      end else begin
        dummyCycle <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Arithmetic flags: ALU update wins over a software write
  always @(posedge clk) begin
    if (sys_rst) begin
      arithFlags_r <= `CSR_NIB_RST;
    end else if (aluValid) begin
      if (aluArith)
        arithFlags_r <= aluFlags;
      else
        arithFlags_r[`CSR_FLAG_Z] <= (logicResult == 8'h00);
    end else if (wrFlags) begin
      arithFlags_r <= regWdata[3:0];
    end
  end

  // System flags: status writes never reach them
  always @(posedge clk) begin
    if (sys_rst || powerUp) begin
      wdtTimeoutFlag <= 1'b0;
      powerdownFlag  <= 1'b0;
    end else begin
      if (wdtTimeout)
        wdtTimeoutFlag <= 1'b1;
      else if (wdtClearInstr || haltInstr)
        wdtTimeoutFlag <= 1'b0;
      if (haltInstr)
        powerdownFlag <= 1'b1;
      else if (wdtClearInstr)
        powerdownFlag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  // Status image: bits 7..6 zero, no auto save logic exists
  always @* begin
    flagsRead = {2'b00, wdtTimeoutFlag, powerdownFlag,
                 arithFlags_r};
  end

  // Read mux; indirect ports read zero as they are not physical
  always @* begin
    rdataNxt = 8'h00;
    case (regAddr)
      `CSR_ADDR_PTR_A:    rdataNxt = memPointerA_r;
      `CSR_ADDR_PTR_B:    rdataNxt = memPointerB_r;
      `CSR_ADDR_BANK:     rdataNxt = {7'h00, bankSelectBit_r};
      `CSR_ADDR_ACC:      rdataNxt = accumulator;
      `CSR_ADDR_PCL:      rdataNxt = pcLowByte;
      `CSR_ADDR_TBL_LO:   rdataNxt = tablePtrLow_r;
      `CSR_ADDR_TBL_HI_L: rdataNxt = tableHighLatch_r;
      `CSR_ADDR_FLAGS:    rdataNxt = flagsRead;
      `CSR_ADDR_TBL_HI_P: rdataNxt = tablePtrHigh_r;
      default:            rdataNxt = 8'h00;
    endcase
  end

  // Registered read data
  always @(posedge clk) begin
    if (sys_rst)
      regRdata <= 8'h00;
    else if (regRead && isSfr)
      regRdata <= rdataNxt;
  end

endmodule

// ==== pkg/csr_consts.vh ====
/*
  Constants for the core special registers: register addresses, field
  positions, reset values and timing counts.
  Assumes it is included by bare name from design files.
*/
`ifndef CSR_CONSTS_VH
`define CSR_CONSTS_VH

// ----------------------------------------------------------------
// Special register addresses (same in either bank)
// ----------------------------------------------------------------
`define CSR_ADDR_IND_A     8'h00
`define CSR_ADDR_PTR_A     8'h01
`define CSR_ADDR_IND_B     8'h02
`define CSR_ADDR_PTR_B     8'h03
`define CSR_ADDR_BANK      8'h04
`define CSR_ADDR_ACC       8'h05
`define CSR_ADDR_PCL       8'h06
`define CSR_ADDR_TBL_LO    8'h07
`define CSR_ADDR_TBL_HI_L  8'h08
`define CSR_ADDR_FLAGS     8'h0a
`define CSR_ADDR_TBL_HI_P  8'h0c
`define CSR_SFR_TOP        8'h43

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CSR_BANK_BIT       0
`define CSR_FLAG_TO        5
`define CSR_FLAG_PD        4
`define CSR_FLAG_OV        3
`define CSR_FLAG_Z         2
`define CSR_FLAG_AC        1
`define CSR_FLAG_C         0
`define CSR_BANK_RST       1'h0
`define CSR_BYTE_RST       8'h00
`define CSR_NIB_RST        4'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CSR_PCL_DUMMY_CYC  2'h1

`endif

// ==== hw/csr_flag_unit.v ====
/*
  Arithmetic flag generator: carry, half carry, zero, overflow for the
  result of an add or subtract; the core forms zero for logic results.
  Assumes operands and operation select arrive on the core clock.
*/
`timescale 1ns/1ps

module csr_flag_unit (
  input  wire [7:0] opA,
  input  wire [7:0] opB,
  input  wire       isSub,
  input  wire       carryIn,
  input  wire       useCarry,
  output wire [7:0] sum,
  output wire [3:0] flags
);

  // ----------------------------------------------------------------
  // Adder with nibble carry
  // ----------------------------------------------------------------
  wire [7:0] bOp;
  wire       cin;
  wire [4:0] lowSum;
  wire [3:0] hiLow;
  wire [3:0] hiSum;
  wire       carry7;
  wire       carry8;

  // Subtract adds the complement; carry set means no borrow
  assign bOp    = isSub ? ~opB : opB;
  assign cin    = useCarry ? carryIn : isSub;
  assign lowSum = {1'b0, opA[3:0]} + {1'b0, bOp[3:0]} + {4'h0, cin};
  assign hiLow  = {1'b0, opA[6:4]} + {1'b0, bOp[6:4]}
                  + {3'h0, lowSum[4]};
  assign carry7 = hiLow[3];
  assign hiSum  = {3'h0, opA[7]} + {3'h0, bOp[7]} + {3'h0, carry7};
  assign carry8 = hiSum[1];
  assign sum    = {hiSum[0], hiLow[2:0], lowSum[3:0]};

  // Overflow: carry into MSB differs from carry out
  assign flags = {carry7 ^ carry8, sum == 8'h00, lowSum[4], carry8};

endmodule

// ==== verif/csr_core_regs_chk.sv ====
/*
  Checker for the core special registers, bound to the design top.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "csr_consts.vh"

module csr_core_regs_chk (
  input wire       clk,
  input wire       sys_rst,
  input wire       regWrite,
  input wire       regRead,
  input wire       indirect,
  input wire       usePtrB,
  input wire [7:0] regAddr,
  input wire [7:0] regWdata,
  input wire       aluValid,
  input wire       aluArith,
  input wire [7:0] logicResult,
  input wire       powerUp,
  input wire       wdtTimeout,
  input wire       wdtClearInstr,
  input wire       haltInstr,
  input wire       memBank,
  input wire       memAccess,
  input wire       pcLoad,
  input wire [7:0] pcLowByte,
  input wire       dummyCycle,
  input wire [7:0] accumulator,
  input wire       wdtTimeoutFlag,
  input wire       powerdownFlag
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Decoded access and event classes
  wire anyAcc  = regWrite | regRead;
  wire pclWr   = regWrite & ~indirect & (regAddr == `CSR_ADDR_PCL);
  wire quietPd = ~powerUp & ~wdtClearInstr & ~haltInstr;
  wire quietTo = quietPd & ~wdtTimeout;

  pcl_jump_a: assert property (pclWr |=> pcLoad && dummyCycle
    && pcLowByte == $past(regWdata)) else $error("pc low write no jump");
  dummy_cause_a: assert property (dummyCycle |-> $past(pclWr))
    else $error("dummy cycle without pc low write");
  direct_bank0_a: assert property (anyAcc && !indirect
    && regAddr > `CSR_SFR_TOP |=> memAccess && !memBank)
    else $error("direct access left bank 0");
  ptra_bank0_a: assert property (anyAcc && indirect && !usePtrB
    |=> memAccess && !memBank) else $error("pointer A left bank 0");
  sfr_local_a: assert property (anyAcc && !indirect && regAddr > 8'h03
    && regAddr <= `CSR_SFR_TOP |=> !memAccess)
    else $error("special register reached memory");
  to_hold_a: assert property (quietTo |=> $stable(wdtTimeoutFlag))
    else $error("time-out flag moved without cause");
  pd_hold_a: assert property (quietPd |=> $stable(powerdownFlag))
    else $error("power-down flag moved without cause");
  to_set_a: assert property (wdtTimeout && !powerUp |=> wdtTimeoutFlag)
    else $error("time-out flag not set");
  pd_set_a: assert property (haltInstr && !powerUp |=> powerdownFlag)
    else $error("power-down flag not set");
  pd_clear_a: assert property (wdtClearInstr && !haltInstr
    |=> !powerdownFlag) else $error("power-down flag not cleared");
  acc_logic_a: assert property (aluValid && !aluArith
    |=> accumulator == $past(logicResult)) else $error("acc missed result");
endmodule

bind csr_core_regs csr_core_regs_chk i_csr_core_regs_chk (.clk, .sys_rst,
  .regWrite, .regRead, .indirect, .usePtrB, .regAddr, .regWdata,
  .aluValid, .aluArith, .logicResult, .powerUp, .wdtTimeout,
  .wdtClearInstr, .haltInstr, .memBank, .memAccess, .pcLoad, .pcLowByte,
  .dummyCycle, .accumulator, .wdtTimeoutFlag, .powerdownFlag);

// ==== verif/csr_exec_model.sv ====
/*
  Execution unit model: issues register accesses one at a time.
  Assumes its task is called from the bench between clock edges.
*/
`timescale 1ns/1ps

module csr_exec_model (
  input  wire       clk,
  output reg        regWrite,
  output reg        regRead,
  output reg        indirect,
  output reg        usePtrB,
  output reg  [7:0] regAddr,
  output reg  [7:0] regWdata
);
  // Idle bus at time zero
  initial begin
    regWrite = 1'b0;
    regRead  = 1'b0;
    indirect = 1'b0;
    usePtrB  = 1'b0;
    regAddr  = 8'hff;
    regWdata = 8'h00;
  end

  // One access, then release with inverted address and data
  task acc(input w, input r, input ind, input b,
           input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      regWrite <= w;
      regRead  <= r;
      indirect <= ind;
      usePtrB  <= b;
      regAddr  <= a;
      regWdata <= d;
      @(posedge clk);
      regWrite <= 1'b0;
      regRead  <= 1'b0;
      regAddr  <= ~a;
      regWdata <= ~d;
      #1;
    end
  endtask
endmodule

// ==== verif/testbench.sv ====
/*
  Self-checking bench for the core special registers.
  Assumes the checker is bound to the design elsewhere.
*/
`timescale 1ns/1ps

module testbench;
  reg         clk, sys_rst, idleSleep, aluArith, aluSub, aluUseCarry;
  reg  [6:0]  ev;
  reg  [7:0]  aluOpB, logicResult;
  reg  [15:0] progWord;
  integer     failures, comparisons;
  wire        powerUp, wdtReset, wdtTimeout, wdtClearInstr, haltInstr;
  wire        tableRead, aluValid, regWrite, regRead, indirect, usePtrB;
  wire [7:0]  regAddr, regWdata, regRdata, pcLowByte, accumulator;
  wire [7:0]  memAddr;
  wire        memBank, memAccess, pcLoad, dummyCycle;
  wire        wdtTimeoutFlag, powerdownFlag;
  wire [15:0] tableAddr;

  // Event pulses share one vector
  assign {powerUp, wdtReset, wdtTimeout, wdtClearInstr, haltInstr,
          tableRead, aluValid} = ev;

  csr_exec_model i_csr_exec_model (.clk, .regWrite, .regRead, .indirect,
    .usePtrB, .regAddr, .regWdata);
  csr_core_regs i_csr_core_regs (.clk, .sys_rst, .powerUp, .wdtReset,
    .idleSleep, .regWrite, .regRead, .indirect, .usePtrB, .regAddr,
    .regWdata, .aluValid, .aluArith, .aluSub, .aluUseCarry, .aluOpB,
    .logicResult, .tableRead, .progWord, .wdtTimeout, .wdtClearInstr,
    .haltInstr, .regRdata, .memBank, .memAddr, .memAccess, .pcLoad,
    .pcLowByte, .dummyCycle, .tableAddr, .accumulator, .wdtTimeoutFlag,
    .powerdownFlag);

  // Clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Shared drivers and comparison
  task wr(input [7:0] a, input [7:0] d);
    i_csr_exec_model.acc(1'b1, 1'b0, 1'b0, 1'b0, a, d);
  endtask
  task rd(input [7:0] a);
    i_csr_exec_model.acc(1'b0, 1'b1, 1'b0, 1'b0, a, 8'h00);
  endtask
  task pulse(input [6:0] e, input slp);
    begin
      @(posedge clk);
      ev        <= e;
      idleSleep <= slp;
      @(posedge clk);
      ev        <= 7'h00;
      #1;
    end
  endtask
  task ck(input [15:0] got, input [15:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  // Bank bit width and bank routing
  task t_bank;
    begin
      wr(8'h04, 8'hff);
      wr(8'h03, 8'h40);
      wr(8'h01, 8'h22);
      rd(8'h04);
      ck(regRdata, 8'h01);
      i_csr_exec_model.acc(1'b0, 1'b1, 1'b1, 1'b1, 8'h00, 8'h00);
      ck({memAccess, memBank, memAddr}, 10'h340);
      i_csr_exec_model.acc(1'b1, 1'b0, 1'b1, 1'b0, 8'h00, 8'h5a);
      ck({memAccess, memBank, memAddr}, 10'h222);
      rd(8'h60);
      ck({memAccess, memBank, memAddr}, 10'h260);
      wr(8'h05, 8'h3c);
      rd(8'h05);
      ck({memAccess, regRdata}, 9'h03c);
    end
  endtask

  // Bank bit across each kind of reset
  task t_brst;
    begin
      pulse(7'h20, 1'b1);
      rd(8'h04);
      ck(regRdata, 8'h01);
      pulse(7'h20, 1'b0);
      rd(8'h04);
      ck(regRdata, 8'h00);
      wr(8'h04, 8'h01);
      pulse(7'h40, 1'b0);
      rd(8'h04);
      ck(regRdata, 8'h00);
      wr(8'h04, 8'h01);
      @(posedge clk);
      sys_rst <= 1'b1;
      @(posedge clk);
      sys_rst <= 1'b0;
      rd(8'h04);
      ck(regRdata, 8'h00);
    end
  endtask

  // System flags: read-only, set and cleared by events
  task t_flags;
    begin
      wr(8'h0a, 8'hff);
      rd(8'h0a);
      ck(regRdata, 8'h0f);
      pulse(7'h10, 1'b0);
      rd(8'h0a);
      ck(regRdata, 8'h2f);
      wr(8'h0a, 8'h00);
      rd(8'h0a);
      ck(regRdata, 8'h20);
      pulse(7'h04, 1'b0);
      ck({wdtTimeoutFlag, powerdownFlag}, 2'b01);
      pulse(7'h08, 1'b0);
      ck({wdtTimeoutFlag, powerdownFlag}, 2'b00);
    end
  endtask

  // Jump through pc low byte, one dummy cycle
  task t_pcl;
    begin
      wr(8'h06, 8'h55);
      ck({pcLoad, dummyCycle, pcLowByte}, 10'h355);
      @(posedge clk);
      #1;
      ck({pcLoad, dummyCycle}, 2'b00);
    end
  endtask

  // Table pointers, address and high-byte latch
  task t_table;
    begin
      wr(8'h07, 8'h34);
      wr(8'h0c, 8'h12);
      @(posedge clk);
      #1;
      ck(tableAddr, 16'h1234);
      progWord <= 16'habcd;
      pulse(7'h02, 1'b0);
      rd(8'h08);
      ck(regRdata, 8'hab);
    end
  endtask

  // Accumulator results and arithmetic flags
  task t_alu;
    begin
      wr(8'h05, 8'h7f);
      aluArith <= 1'b1;
      aluOpB   <= 8'h01;
      pulse(7'h01, 1'b0);
      ck(accumulator, 8'h80);
      rd(8'h0a);
      ck(regRdata, 8'h0a);
      aluArith    <= 1'b0;
      logicResult <= 8'h00;
      pulse(7'h01, 1'b0);
      rd(8'h0a);
      ck({accumulator, regRdata}, 16'h000e);
    end
  endtask

  // Main sequence
  initial begin
    failures = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    idleSleep = 1'b0;
    aluArith = 1'b0;
    aluSub = 1'b0;
    aluUseCarry = 1'b0;
    ev = 7'h00;
    aluOpB = 8'h00;
    logicResult = 8'h00;
    progWord = 16'h0000;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    t_bank;
    t_brst;
    t_flags;
    t_pcl;
    t_table;
    t_alu;
    give_verdict;
  end

  // Watchdog against a hang
  initial begin
    #100000;
    failures = failures + 1;
    give_verdict;
  end
endmodule
